// ===== rtl/aavs_pkg.sv
package aavs_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADR_CTRL      = 8'h00;
  localparam logic [7:0] ADR_LIMIT     = 8'h01;
  localparam logic [7:0] ADR_RECOV     = 8'h02;
  localparam logic [7:0] ADR_REC_CEIL  = 8'h03;
  localparam logic [7:0] ADR_PLAY_CEIL = 8'h04;
  localparam logic [7:0] ADR_REC_GAIN  = 8'h05;
  localparam logic [7:0] ADR_PLAY_GAIN = 8'h06;
  localparam logic [7:0] ADR_EXTRA_ATT = 8'h07;
  localparam logic [7:0] ADR_LIVE_GAIN = 8'h08;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CTRL      = 8'h40;
  localparam logic [7:0] RST_LIMIT     = 8'h01;
  localparam logic [7:0] RST_RECOV     = 8'h00;
  localparam logic [7:0] RST_REC_CEIL  = 8'hC5;
  localparam logic [5:0] RST_PLAY_CEIL = 6'h28;
  localparam logic [7:0] RST_GAIN      = 8'h91;
  localparam logic [1:0] RST_EXTRA_ATT = 2'h0;

  // ==========================================================
  // Levels on the stage output magnitude
  localparam logic [33:0] LVL_M2P5 = 34'h0_0000_5FFD;
  localparam logic [33:0] LVL_M4P1 = 34'h0_0000_4FD5;
  localparam logic [33:0] LVL_M6P0 = 34'h0_0000_4027;
  localparam logic [33:0] LVL_M8P5 = 34'h0_0000_301C;
  localparam logic [33:0] LVL_M12  = 34'h0_0000_2027;
  localparam logic [33:0] LVL_FS   = 34'h0_0000_8000;
  localparam logic [33:0] LVL_FS6  = 34'h0_0001_0000;
  localparam logic [33:0] LVL_FS12 = 34'h0_0002_0000;

  // ==========================================================
  // Timing counts in sample periods, mute ramp multiplier and gain shift
  localparam logic [10:0] ZC_BASE   = 11'h080;
  localparam logic [14:0] WAIT_BASE = 15'h0080;
  localparam logic [7:0]  MUTE_LEN  = 8'hF5;
  localparam logic [8:0]  MUTE_MULT = 9'h10B;
  localparam logic [4:0]  GAIN_SHIFT = 5'h19;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic               valid;
    logic signed [15:0] data;
  } aavs_smp_t;

  typedef struct packed {
    logic       filt_pwr;
    logic       mute;
    logic       fast_lim;
    logic       zc_dis;
    logic       play_en;
    logic       rec_en;
    logic       path_sel;
    logic [1:0] zt_sel;
    logic [1:0] att_sel;
    logic [1:0] thr_sel;
    logic [1:0] fr_sel;
    logic [1:0] rg_sel;
    logic [2:0] wt_sel;
  } aavs_cfg_t;

  typedef enum logic [1:0] {
    ST_MANUAL = 2'b00,
    ST_AGC    = 2'b01,
    ST_EXIT   = 2'b10
  } aavs_state_t;

endpackage

// ===== rtl/aavs_top.sv
`timescale 1ns/1ps
module aavs_top
  import aavs_pkg::*;
(
  input  wire logic      CLK_SYS_I,
  input  wire logic      NRST_I,
  input  wire logic      CE_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic      WR_I,
  input  wire logic      RD_I,
  output logic      [7:0] RDATA_O,
  input  wire aavs_smp_t SAMPLE_I,
  output aavs_smp_t      SAMPLE_O,
  output logic      [7:0] LIVE_GAIN_O
);

  // ==========================================================
  // Decoders and saturating subtract
  function automatic logic [16:0] mant_f(input logic [3:0] m);
    case (m)
      4'h0:    mant_f = 17'h10000;
      4'h1:    mant_f = 17'h10B56;
      4'h2:    mant_f = 17'h1172C;
      4'h3:    mant_f = 17'h12388;
      4'h4:    mant_f = 17'h13070;
      4'h5:    mant_f = 17'h13DEA;
      4'h6:    mant_f = 17'h14BFE;
      4'h7:    mant_f = 17'h15AB0;
      4'h8:    mant_f = 17'h16A0A;
      4'h9:    mant_f = 17'h17A11;
      4'hA:    mant_f = 17'h18ACE;
      4'hB:    mant_f = 17'h19C49;
      4'hC:    mant_f = 17'h1AE8A;
      4'hD:    mant_f = 17'h1C199;
      4'hE:    mant_f = 17'h1D581;
      default: mant_f = 17'h1EA4A;
    endcase
  endfunction

  function automatic logic [33:0] lvl_f(input logic [2:0] k);
    case (k)
      3'h0:    lvl_f = LVL_M2P5;
      3'h1:    lvl_f = LVL_M4P1;
      3'h2:    lvl_f = LVL_M6P0;
      3'h3:    lvl_f = LVL_M8P5;
      default: lvl_f = LVL_M12;
    endcase
  endfunction

  function automatic logic [3:0] step_f(input logic [1:0] sel, input logic [1:0] reg_i);
    case ({sel, reg_i})
      4'b0100, 4'b0101, 4'b0110, 4'b0111: step_f = 4'h2;
      4'b1000:                             step_f = 4'h2;
      4'b1001, 4'b1010:                    step_f = 4'h4;
      4'b1011, 4'b1111:                    step_f = 4'h8;
      4'b1101:                             step_f = 4'h2;
      4'b1110:                             step_f = 4'h4;
      default:                             step_f = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] sub_f(input logic [7:0] g, input logic [3:0] s);
    sub_f = (g > {4'h0, s}) ? g - {4'h0, s} : 8'h00;
  endfunction

  // ==========================================================
  // Register file
  aavs_cfg_t   cfg_r;
  logic [7:0]  rec_ceil_r;
  logic [5:0]  play_ceil_r;
  logic [7:0]  rec_gain_r;
  logic [7:0]  play_gain_r;
  logic [1:0]  extra_r;
  logic [7:0]  rdata_r;
  logic [7:0]  gain_r;
  logic [7:0]  ramp_r;

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cfg_r       <= aavs_cfg_t'({RST_CTRL[6:0], RST_LIMIT[5:0], RST_RECOV[6:0]});
      rec_ceil_r  <= RST_REC_CEIL;
      play_ceil_r <= RST_PLAY_CEIL;
      rec_gain_r  <= RST_GAIN;
      play_gain_r <= RST_GAIN;
      extra_r     <= RST_EXTRA_ATT;
    end else if (CE_I && WR_I) begin
      case (ADDR_I)
        ADR_CTRL:      {cfg_r.filt_pwr, cfg_r.mute, cfg_r.fast_lim, cfg_r.zc_dis,
                        cfg_r.play_en, cfg_r.rec_en, cfg_r.path_sel} <= WDATA_I[6:0];
        ADR_LIMIT:     {cfg_r.zt_sel, cfg_r.att_sel, cfg_r.thr_sel} <= WDATA_I[5:0];
        ADR_RECOV:     {cfg_r.fr_sel, cfg_r.rg_sel, cfg_r.wt_sel} <= WDATA_I[6:0];
        ADR_REC_CEIL:  rec_ceil_r  <= WDATA_I;
        ADR_PLAY_CEIL: play_ceil_r <= WDATA_I[5:0];
        ADR_REC_GAIN:  rec_gain_r  <= WDATA_I;
        ADR_PLAY_GAIN: play_gain_r <= WDATA_I;
        ADR_EXTRA_ATT: extra_r     <= WDATA_I[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_r <= 8'h00;
    end else if (CE_I) begin
      rdata_r <= 8'h00;
      if (RD_I) begin
        case (ADDR_I)
          ADR_CTRL:      rdata_r <= {1'b0, cfg_r.filt_pwr, cfg_r.mute, cfg_r.fast_lim,
                                     cfg_r.zc_dis, cfg_r.play_en, cfg_r.rec_en,
                                     cfg_r.path_sel};
          ADR_LIMIT:     rdata_r <= {2'h0, cfg_r.zt_sel, cfg_r.att_sel, cfg_r.thr_sel};
          ADR_RECOV:     rdata_r <= {1'b0, cfg_r.fr_sel, cfg_r.rg_sel, cfg_r.wt_sel};
          ADR_REC_CEIL:  rdata_r <= rec_ceil_r;
          ADR_PLAY_CEIL: rdata_r <= {2'h0, play_ceil_r};
          ADR_REC_GAIN:  rdata_r <= rec_gain_r;
          ADR_PLAY_GAIN: rdata_r <= play_gain_r;
          ADR_EXTRA_ATT: rdata_r <= {6'h00, extra_r};
          ADR_LIVE_GAIN: rdata_r <= gain_r;
          default:       rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Gain datapath and level detection
  logic               tick;
  logic               agc_en;
  logic [7:0]         ceil;
  logic [7:0]         man_gain;
  logic [7:0]         gidx;
  logic signed [33:0] prod;
  logic signed [33:0] scaled;
  logic [33:0]        amp;
  logic signed [15:0] sat;
  logic signed [15:0] att;
  logic signed [33:0] mprod;
  logic [16:0]        mgain;
  logic               above;
  logic               band;
  logic [1:0]         region;

  assign tick     = CE_I & SAMPLE_I.valid;
  assign agc_en   = cfg_r.filt_pwr & (cfg_r.path_sel ? cfg_r.rec_en : cfg_r.play_en);
  assign ceil     = cfg_r.path_sel ? rec_ceil_r : {play_ceil_r, 2'b00} + 8'h01;
  assign man_gain = cfg_r.path_sel ? rec_gain_r : play_gain_r;
  assign gidx     = gain_r - 8'h01;

  always_comb begin
    prod   = SAMPLE_I.data * $signed({1'b0, mant_f(gidx[3:0])});
    scaled = (gain_r == 8'h00) ? 34'sh0 : prod >>> (GAIN_SHIFT - {1'b0, gidx[7:4]});
    amp    = scaled[33] ? 34'(-scaled) : scaled;
    if (scaled > 34'sh0_0000_7FFF) begin
      sat = 16'sh7FFF;
    end else if (scaled < -34'sh0_0000_8000) begin
      sat = -16'sh8000;
    end else begin
      sat = scaled[15:0];
    end
    att   = sat >>> extra_r;
    mgain = 17'(ramp_r) * 17'(MUTE_MULT);
    mprod = att * $signed({1'b0, mgain});
  end

  assign above  = amp >= lvl_f({1'b0, cfg_r.thr_sel});
  assign band   = !above && amp >= lvl_f({1'b0, cfg_r.thr_sel} + 3'h1);
  assign region = (amp >= LVL_FS12) ? 2'h3 : (amp >= LVL_FS6) ? 2'h2 :
                  (amp >= LVL_FS) ? 2'h1 : 2'h0;

  // ==========================================================
  // Control state
  aavs_state_t state_r;
  logic [10:0] zc_cnt_r;
  logic [10:0] exit_cnt_r;
  logic [14:0] wait_cnt_r;
  logic [10:0] setup_q_r;
  logic        prev_sign_r;
  logic        pend_r;
  logic [7:0]  pend_gain_r;
  logic        fast_r;
  logic [10:0] zc_lim;
  logic [14:0] wait_lim;
  logic        cfg_chg;
  logic        zc_det;
  logic        zc_to;
  logic        commit;
  logic        lim_act;
  logic        lim_now;
  logic        lim_def;
  logic        rec_go;
  logic        man_go;
  logic        pend_set;
  logic [8:0]  rec_sum;

  assign zc_lim   = ZC_BASE << cfg_r.zt_sel;
  assign wait_lim = fast_r ? ((WAIT_BASE << cfg_r.wt_sel) >> (cfg_r.fr_sel[1] ? 3'h4 :
                    3'h2 + {2'h0, cfg_r.fr_sel[0]})) - 15'h1 :
                    (WAIT_BASE << cfg_r.wt_sel) - 15'h1;
  assign cfg_chg  = setup_q_r != {cfg_r.zc_dis, cfg_r.zt_sel, cfg_r.att_sel, cfg_r.thr_sel,
                                  cfg_r.fr_sel, cfg_r.rg_sel};
  assign zc_det   = (SAMPLE_I.data[15] != prev_sign_r) || (SAMPLE_I.data == 16'sh0);
  assign zc_to    = zc_cnt_r >= zc_lim - 11'h1;
  assign commit   = tick && pend_r && (zc_det || zc_to);
  assign lim_act  = tick && state_r == ST_AGC && agc_en && above;
  assign lim_now  = lim_act && (cfg_r.zc_dis || (cfg_r.fast_lim && region != 2'h0));
  assign lim_def  = lim_act && !lim_now && !pend_r;
  assign rec_sum  = {1'b0, gain_r} + {7'h00, cfg_r.rg_sel} + 9'h1;
  assign rec_go   = tick && state_r == ST_AGC && agc_en && !above && !band &&
                    wait_cnt_r >= wait_lim && !pend_r && gain_r < ceil;
  assign man_go   = tick && state_r == ST_MANUAL && gain_r != man_gain &&
                    !(pend_r && pend_gain_r == man_gain);
  assign pend_set = lim_def || rec_go || man_go;

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= ST_MANUAL;
    end else if (CE_I) begin
      case (state_r)
        ST_MANUAL: if (agc_en) begin
          state_r <= ST_AGC;
        end
        ST_AGC: if (!agc_en) begin
          state_r <= ST_EXIT;
        end
        ST_EXIT: if (agc_en) begin
          state_r <= ST_AGC;
        end else if (tick && exit_cnt_r >= zc_lim - 11'h1) begin
          state_r <= ST_MANUAL;
        end
        default: state_r <= ST_MANUAL;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      exit_cnt_r <= 11'h000;
    end else if (CE_I) begin
      if (state_r != ST_EXIT || cfg_chg) begin
        exit_cnt_r <= 11'h000;
      end else if (tick) begin
        exit_cnt_r <= exit_cnt_r + 11'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      gain_r      <= RST_GAIN;
      pend_r      <= 1'b0;
      pend_gain_r <= RST_GAIN;
    end else if (CE_I) begin
      if (lim_now) begin
        gain_r <= sub_f(gain_r, 4'h1);
        pend_r <= 1'b0;
      end else if (commit) begin
        gain_r <= pend_gain_r;
        pend_r <= 1'b0;
      end
      if (lim_def) begin
        pend_r      <= 1'b1;
        pend_gain_r <= sub_f(gain_r, step_f(cfg_r.att_sel, region));
      end else if (rec_go) begin
        pend_r      <= 1'b1;
        pend_gain_r <= (rec_sum > {1'b0, ceil}) ? ceil : rec_sum[7:0];
      end else if (man_go) begin
        pend_r      <= 1'b1;
        pend_gain_r <= man_gain;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      zc_cnt_r <= 11'h000;
    end else if (CE_I) begin
      if (!pend_r || pend_set || cfg_chg) begin
        zc_cnt_r <= 11'h000;
      end else if (tick) begin
        zc_cnt_r <= zc_cnt_r + 11'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wait_cnt_r <= 15'h0000;
    end else if (CE_I) begin
      if (state_r != ST_AGC || lim_act || band || rec_go || cfg_chg) begin
        wait_cnt_r <= 15'h0000;
      end else if (tick && wait_cnt_r < wait_lim) begin
        wait_cnt_r <= wait_cnt_r + 15'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fast_r <= 1'b0;
    end else if (CE_I) begin
      if (lim_act && region != 2'h0) begin
        fast_r <= 1'b1;
      end else if (rec_go || state_r != ST_AGC) begin
        fast_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      setup_q_r   <= 11'h000;
      prev_sign_r <= 1'b0;
    end else if (CE_I) begin
      setup_q_r <= {cfg_r.zc_dis, cfg_r.zt_sel, cfg_r.att_sel, cfg_r.thr_sel,
                    cfg_r.fr_sel, cfg_r.rg_sel};
      if (tick) begin
        prev_sign_r <= SAMPLE_I.data[15];
      end
    end
  end

  // ==========================================================
  // Soft mute ramp
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ramp_r <= MUTE_LEN;
    end else if (tick) begin
      if (cfg_r.mute && ramp_r != 8'h00) begin
        ramp_r <= ramp_r - 8'h01;
      end else if (!cfg_r.mute && ramp_r != MUTE_LEN) begin
        ramp_r <= ramp_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SAMPLE_O    <= '0;
      LIVE_GAIN_O <= RST_GAIN;
    end else if (CE_I) begin
      SAMPLE_O.valid <= SAMPLE_I.valid;
      LIVE_GAIN_O    <= gain_r;
      if (tick) begin
        SAMPLE_O.data <= (ramp_r == MUTE_LEN) ? att : mprod[31:16];
      end
    end
  end

  assign RDATA_O = rdata_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!NRST_I);

  sequence s_lim_defer;
    lim_def ##1 pend_r;
  endsequence

  a_extra_att_out: assert property (tick && gain_r == RST_GAIN && ramp_r == MUTE_LEN
    |=> SAMPLE_O.data == ($past(SAMPLE_I.data) >>> $past(extra_r)))
    else $error("extra attenuation output wrong");
  a_path_exit: assert property (CE_I && state_r == ST_AGC && !agc_en
    |=> state_r == ST_EXIT)
    else $error("disabled path did not leave level control");
  a_lim_defer: assert property (s_lim_defer
    |-> pend_gain_r == sub_f($past(gain_r), step_f($past(cfg_r.att_sel), $past(region))))
    else $error("deferred limiter target wrong");
  a_lim_now_step: assert property (lim_now && gain_r != 8'h00
    |=> gain_r == $past(gain_r) - 8'h01)
    else $error("immediate limiter step wrong");
  a_zc_timeout: assert property (commit && !lim_act
    |=> gain_r == $past(pend_gain_r) && !pend_r)
    else $error("pending gain not applied");
  a_rec_ceil: assert property (rec_go |=> pend_gain_r <= $past(ceil))
    else $error("recovery exceeded ceiling");
  a_wait_band: assert property (CE_I && band && state_r == ST_AGC
    |=> wait_cnt_r == 15'h0000)
    else $error("wait timer not reset in band");
  a_exit_hold: assert property (CE_I && state_r == ST_EXIT && !agc_en &&
    exit_cnt_r < zc_lim - 11'h1 |=> state_r != ST_MANUAL)
    else $error("manual mode entered too early");
  a_mute_ramp: assert property (tick && cfg_r.mute && ramp_r != 8'h00
    |=> ramp_r == $past(ramp_r) - 8'h01)
    else $error("mute ramp did not step down");
  a_gain_readback: assert property (CE_I && RD_I && ADDR_I == ADR_LIVE_GAIN
    |=> RDATA_O == $past(gain_r))
    else $error("live gain readback wrong");

endmodule

// ===== tb/aavs_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module aavs_top_tb;
  import aavs_pkg::*;

  logic                   clk;
  logic                   nrst;
  logic                   wr;
  logic                   rd;
  logic                   ce;
  logic            [7:0]  addr;
  logic            [7:0]  wdata;
  logic            [7:0]  rdata;
  logic            [7:0]  live;
  aavs_smp_t              smp_i;
  aavs_smp_t              smp_o;
  int                     mismatches;
  int                     n_tests;
  logic signed     [15:0] mid_a;
  logic signed     [15:0] mid_b;
  logic            [7:0]  rst_tab [9];

  // ==========================================================
  // Clock and device
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  aavs_top u_dut (
    .CLK_SYS_I   (clk),
    .NRST_I      (nrst),
    .CE_I        (ce),
    .ADDR_I      (addr),
    .WDATA_I     (wdata),
    .WR_I        (wr),
    .RD_I        (rd),
    .RDATA_O     (rdata),
    .SAMPLE_I    (smp_i),
    .SAMPLE_O    (smp_o),
    .LIVE_GAIN_O (live)
  );

  // ==========================================================
  // Access tasks
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, rdata, e)
  endtask

  // Sends n samples, sign alternating when alt is set, then lets output settle
  task automatic run(input logic signed [15:0] d, input int n, input bit alt);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      smp_i.valid <= 1'b1;
      smp_i.data <= (alt && i[0]) ? -d : d;
    end
    @(posedge clk);
    smp_i.valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic test_end(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #200000;
    mismatches++;
    $display("[FAIL] watchdog expected finish seen hang");
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    smp_i = '0;
    mismatches = 0;
    n_tests = 0;
    rst_tab = '{RST_CTRL, 8'h01, RST_RECOV, RST_REC_CEIL, 8'h28, 8'h91, 8'h91, 8'h00, 8'h91};
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 9; a++) begin
      rd_chk(8'(a), rst_tab[a], "reset_value");
    end
    wr_reg(8'h09, 8'hFF);
    rd_chk(8'h09, 8'h00, "unmapped");
    wr_reg(ADR_LIVE_GAIN, 8'h00);
    rd_chk(ADR_LIVE_GAIN, 8'h91, "live_read_only");
    ce <= 1'b0;
    wr_reg(ADR_EXTRA_ATT, 8'h03);
    ce <= 1'b1;
    rd_chk(ADR_EXTRA_ATT, 8'h00, "ce_freeze");
    test_end("registers");

    for (int k = 0; k < 4; k++) begin
      wr_reg(ADR_EXTRA_ATT, 8'(k));
      rd_chk(ADR_EXTRA_ATT, 8'(k), "att_reg");
      run(16'sh4000, 4, 1'b0);
      `CHK("att_out", smp_o.data, 16'sh4000 >>> k)
    end
    wr_reg(ADR_EXTRA_ATT, 8'h00);
    test_end("extra_atten");

    wr_reg(ADR_PLAY_GAIN, 8'h00);
    run(16'sh4000, 100, 1'b0);
    `CHK("manual_hold", smp_o.data, 16'sh4000)
    run(16'sh4000, 30, 1'b0);
    `CHK("manual_timeout", smp_o.data, 16'sh0000)
    `CHK("live_mute", live, 8'h00)
    wr_reg(ADR_PLAY_GAIN, 8'h91);
    run(16'sh4000, 130, 1'b0);
    `CHK("manual_back", smp_o.data, 16'sh4000)
    test_end("manual_volume");

    wr_reg(ADR_CTRL, 8'h60);
    run(16'sh4000, 120, 1'b0);
    mid_a = smp_o.data;
    `CHK("mute_mid", (mid_a > 0) && (mid_a < 16'sh4000), 1'b1)
    run(16'sh4000, 130, 1'b0);
    `CHK("mute_low", smp_o.data, 16'sh0000)
    wr_reg(ADR_CTRL, 8'h40);
    run(16'sh4000, 250, 1'b0);
    `CHK("unmute", smp_o.data, 16'sh4000)
    wr_reg(ADR_CTRL, 8'h60);
    run(16'sh4000, 60, 1'b0);
    mid_a = smp_o.data;
    wr_reg(ADR_CTRL, 8'h40);
    run(16'sh4000, 3, 1'b0);
    mid_b = smp_o.data;
    `CHK("mute_reverse", mid_b > mid_a, 1'b1)
    run(16'sh4000, 250, 1'b0);
    `CHK("mute_cancel", smp_o.data, 16'sh4000)
    test_end("soft_mute");

    wr_reg(ADR_PLAY_CEIL, 8'h24);
    wr_reg(ADR_RECOV, 8'h18);
    wr_reg(ADR_CTRL, 8'h4D);
    run(16'sh6000, 2, 1'b0);
    `CHK("other_path", live, 8'h91)
    wr_reg(ADR_CTRL, 8'h4C);
    run(16'sh6000, 1, 1'b0);
    `CHK("limit_one", live, 8'h90)
    run(16'sh6000, 1, 1'b0);
    `CHK("limit_two", live, 8'h8F)
    rd_chk(ADR_LIVE_GAIN, 8'h8F, "live_read");
    run(16'sh4800, 200, 1'b1);
    `CHK("band_hold", live, 8'h8F)
    run(16'sh0100, 120, 1'b1);
    `CHK("wait_hold", live, 8'h8F)
    run(16'sh0100, 20, 1'b1);
    `CHK("recover_clip", live, 8'h91)
    run(16'sh0100, 300, 1'b1);
    `CHK("ceiling_hold", live, 8'h91)
    test_end("limit_recover");

    wr_reg(ADR_PLAY_GAIN, 8'h85);
    wr_reg(ADR_CTRL, 8'h48);
    run(16'sh0100, 100, 1'b0);
    `CHK("exit_hold", live, 8'h91)
    run(16'sh0100, 200, 1'b0);
    `CHK("exit_manual", live, 8'h85)
    wr_reg(ADR_LIMIT, 8'h03);
    wr_reg(ADR_CTRL, 8'h44);
    run(16'sh7FFF, 1, 1'b0);
    `CHK("zc_defer", live, 8'h85)
    run(-16'sh7FFF, 1, 1'b0);
    `CHK("zc_apply", live, 8'h84)
    test_end("zero_cross");
    wrap_up();
  end
endmodule
